/* File: inc/two_wire_eeprom_defs.svh */
// Constants for the two-wire serial data memory and its I/O port register
//
// Behaviour
// - Sixteen bytes of data memory, all reachable over the two-wire bus.
// - Data line is bit 6, clock line bit 7 of port register 06h.
// - Data line is open-drain, always output, released after reset.
// - Clock line is push-pull, always output, high after reset.
// - Internal write cycle lasts at most 4 ms; memory is busy meanwhile.
// - Data changes only while clock is low during bit transfer.
// - Data falling while clock high is a start; commands open with one.
// - Data rising while clock high is a stop; operations close with one.
// - One bit per clock pulse; master decides the byte count.
// - Receiver holds data low through the ninth clock pulse as acknowledge.
// - No acknowledge at all while a write cycle runs.
// - Master ends a read by withholding acknowledge; device releases data.
// - Control byte: device code 1010, three ignored bits, direction bit.
// - Direction one selects read, zero selects write.
// - Device always watches for its code; acknowledges only when idle.
// - Byte write: address byte, data byte, each acknowledged; stop writes.
// - Only the low four address bits select the location.
// - After a byte write the pointer stays on the written location.
// - A stop before the byte write completes aborts without writing.
// - Extra data bits restart loading; stop inside extra byte aborts.
// - Current read acknowledges control byte, sends byte at pointer.
// - Random read sets pointer by write address, then restarts to read.
// - Master acknowledge after a read byte sends the next byte.
`ifndef TWO_WIRE_EEPROM_DEFS_SVH
`define TWO_WIRE_EEPROM_DEFS_SVH

// ==========================================================
// Register map
`define PORT_REG_ADDR      8'h06
`define PORT_REG_RESET     8'hC0
`define PORT_DATA_BIT      6
`define PORT_CLOCK_BIT     7
`define PORT_PIN_COUNT     6

// ==========================================================
// Protocol
`define DEVICE_CODE        4'hA
`define MEM_DEPTH          16
`define MEM_ADDR_W         4
`define BIT_ACK_SLOT       4'h8
`define BIT_LAST_DATA      4'h7

// ==========================================================
// Timing
`define CLK_PERIOD_NS      20
`define WRITE_TIME_NS      4000000

`endif

/* File: inc/two_wire_eeprom_pkg.sv */
// Types for the two-wire serial data memory
package two_wire_eeprom_pkg;

    // ==========================================================
    // Transfer phase of the serial slave
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CTRL,
        PH_ADDR,
        PH_DATA,
        PH_READ
    } phase_t;

endpackage

/* File: rtl/two_wire_eeprom_slave.sv */
// I/O port register with internal two-wire serial data memory
`timescale 1ns/1ps
`include "two_wire_eeprom_defs.svh"

module two_wire_eeprom_slave #(
    parameter int ADDR_W       = 8,
    parameter int WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic                         clk_in,
    input  wire logic                         sys_rst_in,
    input  wire logic [ADDR_W-1:0]            reg_addr_in,
    input  wire logic [7:0]                   reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [7:0]                   reg_rdata_out,
    input  wire logic [`PORT_PIN_COUNT-1:0]   external_port_pins_in,
    output logic      [`PORT_PIN_COUNT-1:0]   external_port_pins_out,
    output logic                              sda_line_out,
    output logic                              scl_line_out,
    output logic                              mem_busy_out
);

    localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

    // ==========================================================
    // Declarations
    logic [7:0]                  mem_r [`MEM_DEPTH];
    logic                        scl_drv_r;
    logic                        sda_drv_r;
    logic [`PORT_PIN_COUNT-1:0]  pins_out_r;
    logic [`PORT_PIN_COUNT-1:0]  pins_meta_r;
    logic [`PORT_PIN_COUNT-1:0]  pins_sync_r;
    logic [7:0]                  rdata_r;
    logic                        scl_q_r;
    logic                        sda_q_r;
    logic                        dev_pull_r;
    two_wire_eeprom_pkg::phase_t phase_r;
    logic [3:0]                  bit_cnt_r;
    logic [7:0]                  shift_r;
    logic                        dir_read_r;
    logic                        host_ack_r;
    logic                        scl_seen_r;
    logic                        data_full_r;
    logic [7:0]                  data_buf_r;
    logic [`MEM_ADDR_W-1:0]      wr_addr_r;
    logic [`MEM_ADDR_W-1:0]      rd_ptr_r;
    logic                        wr_go_r;
    logic [BUSY_W-1:0]           busy_cnt_r;
    logic                        sda_bus;
    logic                        busy;
    logic                        start_ev;
    logic                        stop_ev;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        code_match;
    logic [7:0]                  next_byte;

    // ==========================================================
    // Wired line levels and bus conditions
    assign sda_bus    = sda_drv_r & ~dev_pull_r;
    assign busy       = (busy_cnt_r != '0);
    assign start_ev   = scl_q_r & scl_drv_r & sda_q_r & ~sda_bus;
    assign stop_ev    = scl_q_r & scl_drv_r & ~sda_q_r & sda_bus;
    assign scl_rise   = ~scl_q_r & scl_drv_r;
    assign scl_fall   = scl_q_r & ~scl_drv_r;
    assign code_match = (shift_r[7:4] == `DEVICE_CODE);
    assign next_byte  = mem_r[rd_ptr_r];

    assign reg_rdata_out          = rdata_r;
    assign external_port_pins_out = pins_out_r;
    assign sda_line_out           = sda_bus;
    assign scl_line_out           = scl_drv_r;
    assign mem_busy_out           = busy;

    // ==========================================================
    // Port register writes
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_drv_r  <= 1'b1;
            sda_drv_r  <= 1'b1;
            pins_out_r <= '0;
        end else if (reg_wr_in && reg_addr_in == ADDR_W'(`PORT_REG_ADDR)) begin
            scl_drv_r  <= reg_wdata_in[`PORT_CLOCK_BIT];
            sda_drv_r  <= reg_wdata_in[`PORT_DATA_BIT];
            pins_out_r <= reg_wdata_in[`PORT_PIN_COUNT-1:0];
        end
    end

    // ==========================================================
    // Port pin synchroniser
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pins_meta_r <= '0;
            pins_sync_r <= '0;
        end else begin
            pins_meta_r <= external_port_pins_in;
            pins_sync_r <= pins_meta_r;
        end
    end

    // ==========================================================
    // Port register reads
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_r <= '0;
        end else if (reg_rd_in && reg_addr_in == ADDR_W'(`PORT_REG_ADDR)) begin
            rdata_r <= {scl_drv_r, sda_bus, pins_sync_r};
        end else begin
            rdata_r <= '0;
        end
    end

    // ==========================================================
    // Previous line levels for edge detection
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_drv_r;
            sda_q_r <= sda_bus;
        end
    end

    // ==========================================================
    // Serial slave sequencer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_r     <= two_wire_eeprom_pkg::PH_IDLE;
            bit_cnt_r   <= '0;
            shift_r     <= '0;
            dev_pull_r  <= 1'b0;
            dir_read_r  <= 1'b0;
            host_ack_r  <= 1'b0;
            scl_seen_r  <= 1'b0;
            data_full_r <= 1'b0;
            data_buf_r  <= '0;
            wr_addr_r   <= '0;
            rd_ptr_r    <= '0;
            wr_go_r     <= 1'b0;
        end else begin
            wr_go_r <= 1'b0;
            if (start_ev) begin
                phase_r     <= two_wire_eeprom_pkg::PH_CTRL;
                bit_cnt_r   <= '0;
                scl_seen_r  <= 1'b0;
                dev_pull_r  <= 1'b0;
                data_full_r <= 1'b0;
            end else if (stop_ev) begin
                if (phase_r == two_wire_eeprom_pkg::PH_DATA && data_full_r
                    && bit_cnt_r == 4'h0) begin
                    wr_go_r <= 1'b1;
                end
                phase_r     <= two_wire_eeprom_pkg::PH_IDLE;
                bit_cnt_r   <= '0;
                dev_pull_r  <= 1'b0;
                data_full_r <= 1'b0;
            end else if (phase_r != two_wire_eeprom_pkg::PH_IDLE) begin
                if (scl_rise) begin
                    scl_seen_r <= 1'b1;
                    if (bit_cnt_r < `BIT_ACK_SLOT &&
                        phase_r != two_wire_eeprom_pkg::PH_READ) begin
                        shift_r <= {shift_r[6:0], sda_bus};
                    end
                    if (bit_cnt_r == `BIT_ACK_SLOT) begin
                        host_ack_r <= ~sda_bus;
                    end
                end
                // Fall closing the start condition carries no bit
                if (scl_fall && scl_seen_r) begin
                    if (bit_cnt_r < `BIT_LAST_DATA) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (phase_r == two_wire_eeprom_pkg::PH_DATA &&
                            bit_cnt_r == 4'h0) begin
                            data_full_r <= 1'b0;
                        end
                        if (phase_r == two_wire_eeprom_pkg::PH_READ) begin
                            shift_r    <= {shift_r[6:0], 1'b0};
                            dev_pull_r <= ~shift_r[6];
                        end
                    end else if (bit_cnt_r == `BIT_LAST_DATA) begin
                        bit_cnt_r <= `BIT_ACK_SLOT;
                        case (phase_r)
                            two_wire_eeprom_pkg::PH_CTRL: begin
                                if (code_match && !busy) begin
                                    dev_pull_r <= 1'b1;
                                    dir_read_r <= shift_r[0];
                                end else begin
                                    phase_r <= two_wire_eeprom_pkg::PH_IDLE;
                                end
                            end
                            two_wire_eeprom_pkg::PH_ADDR: begin
                                wr_addr_r  <= shift_r[`MEM_ADDR_W-1:0];
                                rd_ptr_r   <= shift_r[`MEM_ADDR_W-1:0];
                                dev_pull_r <= 1'b1;
                            end
                            two_wire_eeprom_pkg::PH_DATA: begin
                                data_buf_r  <= shift_r;
                                data_full_r <= 1'b1;
                                dev_pull_r  <= 1'b1;
                            end
                            two_wire_eeprom_pkg::PH_READ: begin
                                dev_pull_r <= 1'b0;
                            end
                            default: begin
                                phase_r <= two_wire_eeprom_pkg::PH_IDLE;
                            end
                        endcase
                    end else begin
                        bit_cnt_r <= '0;
                        case (phase_r)
                            two_wire_eeprom_pkg::PH_CTRL: begin
                                if (dir_read_r) begin
                                    phase_r    <= two_wire_eeprom_pkg::PH_READ;
                                    shift_r    <= next_byte;
                                    dev_pull_r <= ~next_byte[7];
                                    rd_ptr_r   <= rd_ptr_r + 4'h1;
                                end else begin
                                    phase_r    <= two_wire_eeprom_pkg::PH_ADDR;
                                    dev_pull_r <= 1'b0;
                                end
                            end
                            two_wire_eeprom_pkg::PH_ADDR: begin
                                phase_r    <= two_wire_eeprom_pkg::PH_DATA;
                                dev_pull_r <= 1'b0;
                            end
                            two_wire_eeprom_pkg::PH_DATA: begin
                                dev_pull_r <= 1'b0;
                            end
                            two_wire_eeprom_pkg::PH_READ: begin
                                if (host_ack_r) begin
                                    shift_r    <= next_byte;
                                    dev_pull_r <= ~next_byte[7];
                                    rd_ptr_r   <= rd_ptr_r + 4'h1;
                                end else begin
                                    phase_r    <= two_wire_eeprom_pkg::PH_IDLE;
                                    dev_pull_r <= 1'b0;
                                end
                            end
                            default: begin
                                phase_r <= two_wire_eeprom_pkg::PH_IDLE;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================================
    // Data memory, not cleared by reset
    always_ff @(posedge clk_in) begin
        if (wr_go_r) begin
            mem_r[wr_addr_r] <= data_buf_r;
        end
    end

    // ==========================================================
    // Internal write cycle timer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_cnt_r <= '0;
        end else if (wr_go_r) begin
            busy_cnt_r <= BUSY_W'(WRITE_CYCLES);
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
        end
    end

endmodule // two_wire_eeprom_slave

/* File: tb/port_pin_model.sv */
// Model of the outside world driving the six general pins
`timescale 1ns/1ps
module port_pin_model (
    input  wire logic       clk_in,
    input  wire logic [5:0] level_in,
    output logic      [5:0] pins_out
);
    // Pins follow the requested level a cycle later, on the rising edge the slave samples on
    always_ff @(posedge clk_in) pins_out <= level_in;
endmodule // port_pin_model

/* File: tb/two_wire_eeprom_properties.sv */
// Checker for the port register and serial memory
`timescale 1ns/1ps
`include "two_wire_eeprom_defs.svh"
module two_wire_eeprom_props #(
    parameter int ADDR_W       = 8,
    parameter int WRITE_CYCLES = 50
) (
    input wire logic                       clk_in,
    input wire logic                       sys_rst_in,
    input wire logic [ADDR_W-1:0]          reg_addr_in,
    input wire logic [7:0]                 reg_wdata_in,
    input wire logic                       reg_wr_in,
    input wire logic                       reg_rd_in,
    input wire logic [7:0]                 reg_rdata_out,
    input wire logic [`PORT_PIN_COUNT-1:0] external_port_pins_in,
    input wire logic [`PORT_PIN_COUNT-1:0] external_port_pins_out,
    input wire logic                       sda_line_out,
    input wire logic                       scl_line_out,
    input wire logic                       mem_busy_out
);
    // =====================================================
    // Helpers
    logic hit;
    logic rel_r;
    int   cnt_r;
    assign hit = (reg_addr_in == ADDR_W'(8'h06));
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) rel_r <= 1'b1;
        else if (reg_wr_in && hit) rel_r <= reg_wdata_in[6];
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) cnt_r <= 0;
        else cnt_r <= mem_busy_out ? cnt_r + 1 : 0;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // =====================================================
    // Properties
    a_read_idle_zero: assert property (!(reg_rd_in && hit) |=>
        reg_rdata_out == 8'h00) else $error("read data not zero");
    a_read_line_levels: assert property (reg_rd_in && hit |=>
        reg_rdata_out[7:6] == {$past(scl_line_out), $past(sda_line_out)})
        else $error("read data lines wrong");
    a_clock_follows: assert property (reg_wr_in && hit |=>
        scl_line_out == $past(reg_wdata_in[7])) else $error("clock wrong");
    a_pins_follow: assert property (reg_wr_in && hit |=>
        external_port_pins_out == $past(reg_wdata_in[5:0]))
        else $error("pin outputs wrong");
    a_pull_low_wins: assert property (!rel_r |-> !sda_line_out)
        else $error("data not pulled low");
    a_quiet_busy: assert property (mem_busy_out && rel_r |->
        sda_line_out) else $error("pulled data while busy");
    a_stable_high: assert property (scl_line_out && $past(scl_line_out)
        && rel_r && $past(rel_r) |-> $stable(sda_line_out))
        else $error("data moved with clock high");
    a_busy_bound: assert property (mem_busy_out |->
        cnt_r < WRITE_CYCLES) else $error("busy too long");
    a_busy_length: assert property ($fell(mem_busy_out) |->
        cnt_r == WRITE_CYCLES) else $error("busy length wrong");
    a_write_at_stop: assert property ($rose(mem_busy_out) |->
        scl_line_out && sda_line_out && $past(scl_line_out))
        else $error("write began without stop");
endmodule // two_wire_eeprom_props

bind two_wire_eeprom_slave two_wire_eeprom_props #(.ADDR_W(ADDR_W),
    .WRITE_CYCLES(WRITE_CYCLES)) u_two_wire_eeprom_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .external_port_pins_in(external_port_pins_in),
    .external_port_pins_out(external_port_pins_out),
    .sda_line_out(sda_line_out), .scl_line_out(scl_line_out),
    .mem_busy_out(mem_busy_out));

/* File: tb/two_wire_eeprom_slave_test.sv */
// Self-checking bench for the port register and serial memory
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module two_wire_eeprom_slave_test;
    localparam int WC = 400;
    logic       clk_in, sys_rst_in, reg_wr_in, reg_rd_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, v;
    logic [5:0] pins_in, pins_out, lvl;
    logic       sda_line_out, scl_line_out, mem_busy_out, ack, s;
    int         err_total, comparisons, cyc;
    two_wire_eeprom_slave #(.ADDR_W(8), .WRITE_CYCLES(WC))
        u_two_wire_eeprom_slave (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .external_port_pins_in(pins_in),
        .external_port_pins_out(pins_out), .sda_line_out(sda_line_out),
        .scl_line_out(scl_line_out), .mem_busy_out(mem_busy_out));
    port_pin_model u_port_pin_model (.clk_in(clk_in), .level_in(lvl),
        .pins_out(pins_in));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // =====================================================
    // Register bus and line tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask
    task automatic ln(input logic c, input logic d);
        wr(8'h06, {c, d, 6'h15});
        repeat (3) @(posedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        ln(1'b0, b);
        ln(1'b1, b);
        rd(8'h06, v);
        r = v[6];
        ln(1'b0, b);
    endtask
    task automatic start();
        ln(1'b0, 1'b1);
        ln(1'b1, 1'b1);
        ln(1'b1, 1'b0);
        ln(1'b0, 1'b0);
    endtask
    task automatic stop();
        ln(1'b0, 1'b0);
        ln(1'b1, 1'b0);
        ln(1'b1, 1'b1);
    endtask
    task automatic tx(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic cmd(input logic [7:0] c);
        start();
        tx(c);
    endtask
    task automatic rx(input logic m_ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~m_ack, s);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < WC + 20 && mem_busy_out; i++) @(posedge clk_in);
        #1;
        `CHK("busy end", 1'b0, mem_busy_out)
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        cmd(8'hA0);
        tx(a);
        tx(d);
        `CHK("data ack", 1'b1, ack)
        stop();
        `CHK("busy", 1'b1, mem_busy_out)
        wait_idle();
    endtask
    task automatic wrap_up();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            wrap_up();
        end
    end
    // =====================================================
    // Scenarios
    initial begin
        {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
        lvl = 6'h2A;
        sys_rst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd(8'h06, v);
        `CHK("port reset", 8'hEA, v)
        wr(8'h06, 8'hD5);
        wr(8'h07, 8'h00);
        `CHK("pins out", 6'h15, pins_out)
        rd(8'h07, v);
        `CHK("unmapped", 8'h00, v)
        cmd(8'hA0);
        `CHK("ctrl ack", 1'b1, ack)
        tx(8'hF3);
        `CHK("addr ack", 1'b1, ack)
        tx(8'h5A);
        stop();
        cmd(8'hA0);
        `CHK("busy poll", 1'b0, ack)
        stop();
        wait_idle();
        cmd(8'hA0);
        `CHK("poll ack", 1'b1, ack)
        stop();
        cmd(8'hA1);
        `CHK("read ack", 1'b1, ack)
        rx(1'b0, v);
        `CHK("current", 8'h5A, v)
        `CHK("released", 1'b1, sda_line_out)
        stop();
        cmd(8'hB0);
        `CHK("bad code", 1'b0, ack)
        stop();
        cmd(8'hA0);
        tx(8'h02);
        stop();
        `CHK("abort", 1'b0, mem_busy_out)
        cmd(8'hA0);
        tx(8'h04);
        tx(8'h77);
        for (int i = 0; i < 4; i++) bit_io(1'b1, s);
        stop();
        `CHK("extra abort", 1'b0, mem_busy_out)
        bw(8'h0F, 8'h3C);
        bw(8'h00, 8'hC3);
        cmd(8'hA0);
        tx(8'h0F);
        cmd(8'hA1);
        rx(1'b1, v);
        `CHK("random", 8'h3C, v)
        rx(1'b0, v);
        `CHK("wrap", 8'hC3, v)
        stop();
        wrap_up();
    end
endmodule // two_wire_eeprom_slave_test
